// ==== logic/ncf_pkg.sv ====
// Constants shared by the comb filter, colour demodulator and output FIFO.
package ncf_pkg;
	localparam int SAMPLE_W   = 8;                  // Converter sample width.
	localparam int LUMA_W     = SAMPLE_W + 1;       // Sum of two samples.
	localparam int CHROMA_W   = SAMPLE_W + 1;       // Signed difference of two samples.
	localparam int DIFF_W     = CHROMA_W + 1;       // Room to negate the most negative chroma.
	localparam int LINE_LEN   = 910;                // Samples per line at four times subcarrier.
	localparam int PTR_W      = 10;                 // Index width of the line memory.
	localparam int PHASE_W    = 2;                  // Carrier phase counter, 90 degrees a step.
	localparam int FIFO_DEPTH = 8;
	localparam int WORD_W     = LUMA_W + CHROMA_W + 2 * DIFF_W;
	localparam logic [PTR_W-1:0]   PTR_LAST    = 10'h38d;  // LINE_LEN - 1.
	localparam logic [PTR_W-1:0]   PTR_RESET   = 10'h000;
	localparam logic [PHASE_W-1:0] PHASE_RESET = 2'h0;
	// Weight encoding of a sampled carrier value.
	typedef enum logic [1:0] {
		NCF_W_ZERO = 2'h0,
		NCF_W_POS  = 2'h1,
		NCF_W_NEG  = 2'h3
	} ncf_weight_t;
endpackage

// ==== logic/ncf_fifo.sv ====
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ncf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointers wrap at the depth, which need not be a power of two.
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (push) begin
			next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage carries no reset; only slots written since reset are ever read out.
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

// ==== logic/ncf_comb_demod.sv ====
// Line-delay comb filter and colour demodulator for sampled composite video.
// Operation
// [RULE1] Delay composite samples one line in memory.
// [RULE2] Luma is current plus delayed sample.
// [RULE3] Chroma is current minus delayed sample.
// [RULE4] R-Y is chroma times sine sequence.
// [RULE5] B-Y is chroma times cosine sequence.
// [RULE6] Carrier weights only one, zero, minus one.
// [RULE7] Pass, zero, or negate chroma per weight.
// [RULE8] One sample per clock; reset clears state. The line memory is not cleared by reset.
// [RULE9] Converter clocks at four-times subcarrier, burst-locked.
`timescale 1ns/1ps
module ncf_comb_demod (
	input  wire logic                             clock,
	input  wire logic                             rstn,
	input  wire logic                             in_valid,
	output logic                                  in_ready,
	input  wire logic [ncf_pkg::SAMPLE_W-1:0]     in_sample,
	output logic                                  out_valid,
	input  wire logic                             out_ready,
	output logic      [ncf_pkg::LUMA_W-1:0]       out_luma,
	output logic      [ncf_pkg::CHROMA_W-1:0]     out_chroma,
	output logic      [ncf_pkg::DIFF_W-1:0]       out_r_y,
	output logic      [ncf_pkg::DIFF_W-1:0]       out_b_y
);
	import ncf_pkg::*;

	logic [SAMPLE_W-1:0] line_mem [LINE_LEN];
	logic [PTR_W-1:0]    line_ptr;
	logic [PTR_W-1:0]    next_line_ptr;
	logic [PHASE_W-1:0]  phase;
	logic [PHASE_W-1:0]  next_phase;
	logic [SAMPLE_W-1:0] delayed;
	logic                accept;
	ncf_weight_t         sin_w;
	ncf_weight_t         cos_w;

	logic                st_valid;
	logic [LUMA_W-1:0]   st_luma;
	logic [CHROMA_W-1:0] st_chroma;
	logic [DIFF_W-1:0]   st_r_y;
	logic [DIFF_W-1:0]   st_b_y;
	logic [PHASE_W-1:0]  st_phase;
	logic                next_st_valid;
	logic [LUMA_W-1:0]   next_st_luma;
	logic [CHROMA_W-1:0] next_st_chroma;
	logic [DIFF_W-1:0]   next_st_r_y;
	logic [DIFF_W-1:0]   next_st_b_y;
	logic [PHASE_W-1:0]  next_st_phase;

	logic                fifo_in_ready;
	logic [WORD_W-1:0]   fifo_out_word;

	// Weights a chroma sample by a carrier value without a multiplier.
	function automatic logic [DIFF_W-1:0] weigh(input logic [CHROMA_W-1:0] c, input ncf_weight_t w);
		logic [DIFF_W-1:0] ext;
		ext = {c[CHROMA_W-1], c};
		case (w)
			NCF_W_POS: weigh = ext;                   // RULE7
			NCF_W_NEG: weigh = DIFF_W'(~ext + 1'b1);  // RULE7
			default:   weigh = '0;                    // RULE7
		endcase
	endfunction

	// The stage advances only when it is empty or the FIFO can take its word, so a stall
	// downstream holds the input back instead of dropping samples.
	assign accept   = in_valid && in_ready;
	assign in_ready = !st_valid || fifo_in_ready;  // RULE8
	assign delayed  = line_mem[line_ptr];  // RULE1

	// Sampled sine and cosine at 90 degrees a sample: 0,1,0,-1 and 1,0,-1,0.
	// The phase only lines up with the burst if the sample clock is locked to it.
	always_comb begin
		case (phase)  // RULE6 RULE9
			2'h0: begin
				sin_w = NCF_W_ZERO;
				cos_w = NCF_W_POS;
			end
			2'h1: begin
				sin_w = NCF_W_POS;
				cos_w = NCF_W_ZERO;
			end
			2'h2: begin
				sin_w = NCF_W_ZERO;
				cos_w = NCF_W_NEG;
			end
			default: begin
				sin_w = NCF_W_NEG;
				cos_w = NCF_W_ZERO;
			end
		endcase
	end

	// Next values of the line pointer, carrier phase and output stage.
	always_comb begin
		next_line_ptr  = line_ptr;
		next_phase     = phase;
		next_st_valid  = st_valid && !fifo_in_ready;
		next_st_luma   = st_luma;
		next_st_chroma = st_chroma;
		next_st_r_y    = st_r_y;
		next_st_b_y    = st_b_y;
		next_st_phase  = st_phase;
		if (accept) begin
			next_line_ptr  = (line_ptr == PTR_LAST) ? PTR_RESET : line_ptr + 1'b1;  // RULE1
			next_phase     = phase + 1'b1;  // RULE8
			next_st_valid  = 1'b1;
			next_st_luma   = {1'b0, in_sample} + {1'b0, delayed};  // RULE2
			next_st_chroma = {1'b0, in_sample} - {1'b0, delayed};  // RULE3
			next_st_r_y    = weigh({1'b0, in_sample} - {1'b0, delayed}, sin_w);  // RULE4
			next_st_b_y    = weigh({1'b0, in_sample} - {1'b0, delayed}, cos_w);  // RULE5
			next_st_phase  = phase;
		end
	end

	// Reset clears the phase, pointer and pipeline so the sequence restarts at zero.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin  // RULE8
			line_ptr  <= PTR_RESET;
			phase     <= PHASE_RESET;
			st_valid  <= 1'b0;
			st_luma   <= '0;
			st_chroma <= '0;
			st_r_y    <= '0;
			st_b_y    <= '0;
			st_phase  <= PHASE_RESET;
		end else begin
			line_ptr  <= next_line_ptr;
			phase     <= next_phase;
			st_valid  <= next_st_valid;
			st_luma   <= next_st_luma;
			st_chroma <= next_st_chroma;
			st_r_y    <= next_st_r_y;
			st_b_y    <= next_st_b_y;
			st_phase  <= next_st_phase;
		end
	end

	// Line memory is read and rewritten at the same index, like a dual-port FIFO.
	// It has no reset, so the first line out of reset pairs with stale data.
	// Writes wait for reset to end: an offer held through reset is not taken and must not overwrite the old line.
	always_ff @(posedge clock) begin
		if (accept && rstn) begin
			line_mem[line_ptr] <= in_sample;  // RULE1
		end
	end

	// Output FIFO decouples the sample-rate pipeline from the consumer.
	ncf_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rstn      (rstn),
		.in_valid  (st_valid),
		.in_ready  (fifo_in_ready),
		.in_data   ({st_luma, st_chroma, st_r_y, st_b_y}),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (fifo_out_word)
	);

	assign out_luma   = fifo_out_word[WORD_W-1 -: LUMA_W];
	assign out_chroma = fifo_out_word[2*DIFF_W +: CHROMA_W];
	assign out_r_y    = fifo_out_word[DIFF_W +: DIFF_W];
	assign out_b_y    = fifo_out_word[0 +: DIFF_W];

	// Checks on the pipeline, tied to the sample that caused each result.
	sequence s_accept;
		accept;
	endsequence

	sequence s_stage_loaded;
		st_valid;
	endsequence

	sequence s_wrap;
		accept && line_ptr == PTR_LAST;
	endsequence

	sequence s_push;
		st_valid && fifo_in_ready;
	endsequence

	property p_luma_sum;
		@(posedge clock) disable iff (!rstn)
		s_accept |=> s_stage_loaded ##0 (st_luma == {1'b0, $past(in_sample)} + {1'b0, $past(delayed)});
	endproperty
	a_luma_sum: assert property (p_luma_sum) else $error("Luma is not the line sum.");  // RULE2

	property p_chroma_diff;
		@(posedge clock) disable iff (!rstn)
		s_accept |=> (st_chroma == {1'b0, $past(in_sample)} - {1'b0, $past(delayed)});
	endproperty
	a_chroma_diff: assert property (p_chroma_diff) else $error("Chroma is not the line difference.");  // RULE3

	property p_line_delay;
		@(posedge clock) disable iff (!rstn)
		s_wrap |=> (line_ptr == PTR_RESET);
	endproperty
	a_line_delay: assert property (p_line_delay) else $error("Line pointer did not wrap after one line.");  // RULE1

	property p_r_y_sine;
		@(posedge clock) disable iff (!rstn)
		s_stage_loaded ##0 (st_phase == 2'h1) |-> (st_r_y == {st_chroma[CHROMA_W-1], st_chroma});
	endproperty
	a_r_y_sine: assert property (p_r_y_sine) else $error("R-Y not equal to chroma at sine peak.");  // RULE4

	property p_b_y_cosine;
		@(posedge clock) disable iff (!rstn)
		s_stage_loaded ##0 (st_phase == 2'h2) |-> (st_b_y == DIFF_W'(-$signed({st_chroma[CHROMA_W-1], st_chroma})));
	endproperty
	a_b_y_cosine: assert property (p_b_y_cosine) else $error("B-Y not negated chroma at cosine trough.");  // RULE5

	property p_weight_zero;
		@(posedge clock) disable iff (!rstn)
		s_stage_loaded |-> (st_phase[0] ? (st_b_y == '0) : (st_r_y == '0));
	endproperty
	a_weight_zero: assert property (p_weight_zero) else $error("Zero weight did not block chroma.");  // RULE7

	property p_phase_step;
		@(posedge clock) disable iff (!rstn)
		s_accept ##1 s_accept |=> (phase == PHASE_W'($past(phase, 2) + 2'h2));
	endproperty
	a_phase_step: assert property (p_phase_step) else $error("Phase did not step once per sample.");  // RULE8

	property p_stall_holds;
		@(posedge clock) disable iff (!rstn)
		(st_valid && !fifo_in_ready) |=> st_valid && $stable(st_luma) && $stable(st_phase) && $stable(phase);
	endproperty
	a_stall_holds: assert property (p_stall_holds) else $error("Stage changed while stalled.");  // RULE8

	// The pointer steps by one between wraps, so every index is visited once a line.
	property p_line_step;
		@(posedge clock) disable iff (!rstn)
		(accept && line_ptr != PTR_LAST) |=> (line_ptr == PTR_W'($past(line_ptr) + 1'b1));
	endproperty
	a_line_step: assert property (p_line_step) else $error("Line pointer did not step by one.");  // RULE1

	// The taken sample must wait in memory for the same position on the next line.
	property p_line_store;
		@(posedge clock) disable iff (!rstn)
		s_accept |=> (line_mem[$past(line_ptr)] == $past(in_sample));
	endproperty
	a_line_store: assert property (p_line_store) else $error("Taken sample was not stored in the line memory.");  // RULE1

	// At the sine trough R-Y carries the negated chroma.
	property p_r_y_trough;
		@(posedge clock) disable iff (!rstn)
		s_stage_loaded ##0 (st_phase == 2'h3) |-> (st_r_y == DIFF_W'(-$signed({st_chroma[CHROMA_W-1], st_chroma})));
	endproperty
	a_r_y_trough: assert property (p_r_y_trough) else $error("R-Y not negated chroma at sine trough.");  // RULE4

	// At the cosine peak B-Y carries the chroma unchanged.
	property p_b_y_peak;
		@(posedge clock) disable iff (!rstn)
		s_stage_loaded ##0 (st_phase == 2'h0) |-> (st_b_y == {st_chroma[CHROMA_W-1], st_chroma});
	endproperty
	a_b_y_peak: assert property (p_b_y_peak) else $error("B-Y not equal to chroma at cosine peak.");  // RULE5

	// Sine and cosine are never both non-zero at one phase, so one output is always zero.
	property p_weight_pair;
		@(posedge clock) disable iff (!rstn)
		s_stage_loaded |-> (st_r_y == '0 || st_b_y == '0);
	endproperty
	a_weight_pair: assert property (p_weight_pair) else $error("Both carrier weights were non-zero.");  // RULE6

	// Without a taken sample neither the pointer nor the carrier phase may move.
	property p_idle_holds;
		@(posedge clock) disable iff (!rstn)
		!accept |=> $stable(phase) && $stable(line_ptr);
	endproperty
	a_idle_holds: assert property (p_idle_holds) else $error("Phase or pointer moved without a sample.");  // RULE8

	// An empty stage always takes a sample, so the converter is never held off for nothing.
	property p_ready_empty;
		@(posedge clock) disable iff (!rstn)
		!st_valid |-> in_ready;
	endproperty
	a_ready_empty: assert property (p_ready_empty) else $error("Input refused with an empty stage.");  // RULE8

	// A word handed to the FIFO leaves the stage unless a new sample replaces it.
	property p_stage_drains;
		@(posedge clock) disable iff (!rstn)
		s_push ##0 !accept |=> !st_valid;
	endproperty
	a_stage_drains: assert property (p_stage_drains) else $error("Stage kept a word already handed on.");  // RULE8

	// Once a word enters the FIFO the output side has a word offered on the next edge.
	property p_push_shows;
		@(posedge clock) disable iff (!rstn)
		s_push |=> out_valid;
	endproperty
	a_push_shows: assert property (p_push_shows) else $error("Pushed word not offered at the output.");  // RULE8

	// A word offered to the consumer stands until it is taken.
	property p_out_holds;
		@(posedge clock) disable iff (!rstn)
		(out_valid && !out_ready) |=> out_valid && $stable(out_luma) && $stable(out_chroma)
			&& $stable(out_r_y) && $stable(out_b_y);
	endproperty
	a_out_holds: assert property (p_out_holds) else $error("Output word changed before it was taken.");  // RULE8

	// Every taken sample produces a stage result on the next edge.
	property p_take_loads;
		@(posedge clock) disable iff (!rstn)
		s_accept |=> s_stage_loaded;
	endproperty
	a_take_loads: assert property (p_take_loads) else $error("Taken sample did not reach the stage.");  // RULE8
endmodule

// ==== bench/ncf_adc_model.sv ====
// Converter model that offers one composite sample per cycle.
`timescale 1ns/1ps
module ncf_adc_model (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       go,
	input  wire logic       gap,
	input  wire logic       in_ready,
	output logic            in_valid,
	output logic      [7:0] in_sample
);
	int   cnt = 0;
	int   tick = 0;
	logic took = 1'b0;
	// An offer counts as taken only out of reset, at the edge with ready high.
	always @(posedge clock) took <= in_valid && in_ready && rstn;
	// Offers change at the falling edge and are held until taken.
	initial begin
		in_valid  = 1'b0;
		in_sample = 8'h00;
		forever begin
			@(negedge clock);
			tick++;
			if (took || !in_valid) begin
				if (took) cnt++;
				if (go && !(gap && tick % 3 == 0)) begin
					in_valid  = 1'b1;
					in_sample = 8'(cnt * 37 + (cnt / 910) * 101);
				end else begin
					// A released bus shows no stale value.
					in_valid  = 1'b0;
					in_sample = ~in_sample;
				end
			end
		end
	end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the comb filter and colour demodulator.
`timescale 1ns/1ps
module tb_top;
	import ncf_pkg::*;
	typedef struct {
		logic [LUMA_W-1:0]   l;
		logic [CHROMA_W-1:0] c;
		logic [DIFF_W-1:0]   r;
		logic [DIFF_W-1:0]   b;
		bit                  v;
	} ncf_exp_t;
	logic                clock, rstn, go, gap, out_ready;
	logic                in_valid, in_ready, out_valid;
	logic [SAMPLE_W-1:0] in_sample;
	logic [LUMA_W-1:0]   out_luma;
	logic [CHROMA_W-1:0] out_chroma;
	logic [DIFF_W-1:0]   out_r_y, out_b_y;
	int                  miscompares = 0, n_compared = 0, acc = 0, k = 0, a0;
	logic [7:0]          mem [LINE_LEN];
	bit                  seen [LINE_LEN];
	int                  sinw [4] = '{0, 1, 0, -1};
	int                  cosw [4] = '{1, 0, -1, 0};
	ncf_exp_t            q [$];

	ncf_comb_demod ncf_comb_demod_i (.clock(clock), .rstn(rstn), .in_valid(in_valid), .in_ready(in_ready),
		.in_sample(in_sample), .out_valid(out_valid), .out_ready(out_ready), .out_luma(out_luma),
		.out_chroma(out_chroma), .out_r_y(out_r_y), .out_b_y(out_b_y));
	ncf_adc_model ncf_adc_model_i (.clock(clock), .rstn(rstn), .go(go), .gap(gap), .in_ready(in_ready),
		.in_valid(in_valid), .in_sample(in_sample));

	task automatic check(input logic [15:0] s, input logic [15:0] x);
		n_compared++;
		if (s !== x) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, s, x);
		end
	endtask

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Mirror of the line memory; it survives reset just as the real one does.
	task automatic push_exp();
		ncf_exp_t                 e;
		logic [7:0]               d;
		logic signed [DIFF_W-1:0] c;
		int                       p;
		p = k % LINE_LEN;
		d = mem[p];
		e.v = seen[p];
		e.l = LUMA_W'(in_sample) + LUMA_W'(d);
		c = DIFF_W'(in_sample) - DIFF_W'(d);
		e.c = c[CHROMA_W-1:0];
		e.r = DIFF_W'(c * sinw[k % 4]);
		e.b = DIFF_W'(c * cosw[k % 4]);
		q.push_back(e);
		mem[p] = in_sample;
		seen[p] = 1'b1;
		k++;
		acc++;
	endtask

	task automatic pop_check();
		ncf_exp_t e;
		if (q.size() == 0) begin
			check(16'(out_valid), 16'h0000);
			return;
		end
		e = q.pop_front();
		if (e.v) begin
			check(16'(out_luma), 16'(e.l));
			check(16'(out_chroma), 16'(e.c));
			check(16'(out_r_y), 16'(e.r));
			check(16'(out_b_y), 16'(e.b));
		end
	endtask

	// Scoreboard: outputs are judged before the same edge's new sample is queued.
	always @(posedge clock) begin
		if (!rstn) begin
			q.delete();
			k = 0;
		end else begin
			if (out_valid && out_ready) pop_check();
			if (in_valid && in_ready) push_exp();
		end
	end

	task automatic wait_acc(input int n);
		for (int t = 0; t < 4000 && acc < n; t++) @(negedge clock);
		if (acc < n) begin
			check(16'(acc), 16'(n));
			conclude();
		end
	endtask

	task automatic drain();
		go = 1'b0;
		out_ready = 1'b1;
		for (int t = 0; t < 60 && (out_valid || q.size() != 0); t++) @(negedge clock);
		check(16'(q.size()), 16'h0000);
	endtask

	// Unbroken stream across a line boundary, one sample per clock.
	task automatic t_stream();
		go = 1'b1;
		wait_acc(LINE_LEN + 40);
		a0 = acc;
		repeat (20) @(negedge clock);
		check(16'(acc - a0), 16'h0014);
	endtask

	// Gaps in the input must not shift the line pairing or the carrier phase.
	task automatic t_gap();
		gap = 1'b1;
		wait_acc(acc + 300);
		gap = 1'b0;
		drain();
	endtask

	// Stalled consumer: stage plus FIFO take nine samples, then input is refused.
	task automatic t_fill();
		out_ready = 1'b0;
		a0 = acc;
		go = 1'b1;
		repeat (30) @(negedge clock);
		check(16'(acc - a0), 16'(FIFO_DEPTH + 1));
		check(16'(in_ready), 16'h0000);
		out_ready = 1'b1;
		wait_acc(acc + 50);
	endtask

	// Reset in mid-stream clears phase and pointer but not the line memory.
	task automatic t_reset();
		rstn = 1'b0;
		@(negedge clock);
		check(16'(out_valid), 16'h0000);
		check(16'(in_ready), 16'h0001);
		rstn = 1'b1;
		wait_acc(acc + 400);
		drain();
	endtask

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	initial begin
		rstn = 1'b0;
		go = 1'b0;
		gap = 1'b0;
		out_ready = 1'b1;
		repeat (2) @(negedge clock);
		rstn = 1'b1;
		t_stream();
		t_gap();
		t_fill();
		t_reset();
		conclude();
	end
endmodule
